/* logic/ncs_pkg.sv */
// Constants, carriers and decode helpers for the configuration sequencer.
// Assumes a byte-wide store and register map, each answering a read one cycle later.
package ncs_pkg;

	// ***************************************************************
	// Store and register addresses
	// ***************************************************************
	localparam int NCS_STORE_BYTES = 2048;
	localparam int NCS_STORE_AW = 11;
	localparam logic [15:0] NCS_REG_CTRL = 16'h0E00;
	localparam logic [15:0] NCS_REG_COND = 16'h0E01;
	localparam logic [15:0] NCS_REG_SAVE = 16'h0E02;
	localparam logic [15:0] NCS_REG_LOAD = 16'h0E03;
	localparam logic [15:0] NCS_REG_STATUS = 16'h0D00;
	localparam logic [15:0] NCS_REG_SCR_FIRST = 16'h0E10;
	localparam logic [15:0] NCS_REG_SCR_LAST = 16'h0E3F;
	localparam int NCS_SCR_DEPTH = 48;

	// ***************************************************************
	// Field positions and reset values
	// ***************************************************************
	localparam int NCS_WE_BIT = 0;
	localparam int NCS_SAVE_BIT = 0;
	localparam int NCS_LOAD_BIT = 1;
	localparam int NCS_ST_SAVE_BUSY = 0;
	localparam int NCS_ST_LOAD_BUSY = 1;
	localparam int NCS_ST_DONE = 2;
	localparam int NCS_ST_FAULT = 3;
	localparam logic NCS_WE_RESET = 1'b0;
	localparam logic [3:0] NCS_COND_RESET = 4'h0;
	localparam logic [7:0] NCS_CKS_RESET = 8'h00;

	// ***************************************************************
	// Instruction codes
	// ***************************************************************
	localparam logic [7:0] NCS_INS_DATA_MAX = 8'h7F;
	localparam logic [7:0] NCS_INS_IO_UPDATE = 8'h80;
	localparam logic [7:0] NCS_INS_CAL = 8'hA0;
	localparam logic [7:0] NCS_INS_SYNC = 8'hA1;
	localparam logic [7:0] NCS_INS_COND_FIRST = 8'hB0;
	localparam logic [7:0] NCS_INS_COND_LAST = 8'hCF;
	localparam logic [7:0] NCS_INS_PAUSE = 8'hFE;
	localparam logic [7:0] NCS_INS_END = 8'hFF;

	// Strap pin levels
	localparam logic [1:0] NCS_PIN_LOW = 2'h0;
	localparam logic [1:0] NCS_PIN_OPEN = 2'h1;
	localparam logic [1:0] NCS_PIN_HIGH = 2'h2;

	typedef enum logic [3:0] {
		NCS_ST_IDLE = 4'h0,
		NCS_ST_FETCH = 4'h1,
		NCS_ST_WAIT = 4'h2,
		NCS_ST_DECODE = 4'h3,
		NCS_ST_MOVE_REQ = 4'h4,
		NCS_ST_MOVE_WAIT = 4'h5,
		NCS_ST_CK_REQ = 4'h6,
		NCS_ST_CK_WAIT = 4'h7
	} ncs_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ncs_bus_req_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [NCS_STORE_AW-1:0] addr;
		logic [7:0] wdata;
	} ncs_mem_req_t;

	typedef struct packed {
		logic io_update;
		logic calibrate;
		logic dist_sync;
		logic cond_valid;
		logic [4:0] cond;
	} ncs_event_t;

	function automatic logic ncs_is_scratch(input logic [15:0] addr);
		ncs_is_scratch = (addr >= NCS_REG_SCR_FIRST) && (addr <= NCS_REG_SCR_LAST);
	endfunction

	// Strap pair to condition id; both pins open means no boot download
	function automatic logic [4:0] ncs_strap_id(input logic [1:0] high_pin, input logic [1:0] low_pin);
		logic [3:0] idx;
		idx = 4'(high_pin * 3 + low_pin);
		unique case (idx)
			4'h0: ncs_strap_id = 5'h01;
			4'h1: ncs_strap_id = 5'h02;
			4'h2: ncs_strap_id = 5'h03;
			4'h3: ncs_strap_id = 5'h04;
			4'h5: ncs_strap_id = 5'h05;
			4'h6: ncs_strap_id = 5'h06;
			4'h7: ncs_strap_id = 5'h07;
			4'h8: ncs_strap_id = 5'h08;
			default: ncs_strap_id = 5'h00;
		endcase
	endfunction

	// Default sequence: one full data block from map address 0, I/O update, end
	function automatic logic [7:0] ncs_scr_default(input int idx);
		unique case (idx)
			0: ncs_scr_default = NCS_INS_DATA_MAX;
			1: ncs_scr_default = 8'h00;
			2: ncs_scr_default = 8'h00;
			3: ncs_scr_default = NCS_INS_IO_UPDATE;
			default: ncs_scr_default = NCS_INS_END;
		endcase
	endfunction

endpackage

/* logic/ncs_sequencer.sv */
// Configuration sequencer moving bytes between a nonvolatile store and the register map.
// Assumes store and map read data stand while the registered read strobe is high,
// writes complete in one cycle, and the serial port delivers one-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) Store of 2048 bytes, auto-advancing address pointer
// (R2) Boot load by straps, software saves/restores anytime; the code takes save and load commands only while idle
// (R3) Scratch-pad registers hold the save sequence
// (R4) Scratch pad resets to a default sequence
// (R5) Two modes, save and restore, shared instructions
// (R6) Data instruction 0x00-0x7F, count is value+1
// (R7) 0x80 on restore pulses I/O update
// (R8) 0xA0 on restore starts clock calibration
// (R9) 0xA1 on restore pulses distribution sync
// (R10) 0xB0-0xCF give condition 0 to 31
// (R11) Pause on save freezes pointers, not stored
// (R12) End on save resets both pointers, idles
// (R13) End on restore zeroes store pointer, idles
// (R14) All instructions decoded both modes except pause
// (R15) Data instruction followed by two address bytes
// (R16) Lower-addressed byte holds the address high bits
// (R17) Transfer starts at target and counts upward
// (R18) Save appends one checksum byte per block
// (R19) Restore checksum mismatch sets fault flag
// (R20) All checksums good sets completion flag
// (R21) Save after pause appends after previous sequence
// (R22) Save needs write enable then save command
// (R23) Load command runs stored sequence until end
// (R24) Save reads scratch pad from its first register
// (R25) Restore-busy flag high throughout a download
// (R26) Checksum is modulo-256 sum of payload bytes
// (R27) Save copies other instructions verbatim, pointer+1
module ncs_sequencer #(
	parameter int STORE_BYTES = ncs_pkg::NCS_STORE_BYTES
) (
	input wire logic clk,
	input wire logic srst,
	input wire ncs_pkg::ncs_bus_req_t reg_req,
	output var logic [7:0] reg_rdata,
	output var ncs_pkg::ncs_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	output var ncs_pkg::ncs_bus_req_t map_req,
	input wire logic [7:0] map_rdata,
	input wire logic auto_load_en,
	input wire logic [1:0] config_select_pin_low,
	input wire logic [1:0] config_select_pin_high,
	output var ncs_pkg::ncs_event_t evt,
	output var logic [4:0] active_condition,
	output var logic load_busy
);
	import ncs_pkg::*;
	if (STORE_BYTES < 16 || STORE_BYTES > NCS_STORE_BYTES ||
			(STORE_BYTES & (STORE_BYTES - 1)) != 0) begin
		$error("STORE_BYTES must be a power of two from 16 to 2048");
	end
	localparam logic [NCS_STORE_AW-1:0] PTR_MASK = NCS_STORE_AW'(STORE_BYTES - 1);
	localparam logic [NCS_STORE_AW-1:0] PTR_ZERO = '0;
	localparam logic [5:0] SCR_LAST_IDX = 6'(NCS_SCR_DEPTH - 1);

	// ***************************************************************
	// State
	// ***************************************************************
	ncs_state_t state, next_state;
	logic mode_load, next_mode_load;
	logic [1:0] stage, next_stage;
	logic [7:0] cur, next_cur;
	logic [5:0] sp, next_sp;
	logic [NCS_STORE_AW-1:0] np, next_np;
	logic [7:0] count, next_count;
	logic [7:0] cks, next_cks;
	logic [15:0] map_ptr, next_map_ptr;
	logic [7:0] addr_hi, next_addr_hi;
	logic wr_en, next_wr_en;
	logic [3:0] cond_reg, next_cond_reg;
	logic done, next_done;
	logic fault, next_fault;
	logic [4:0] strap_id, next_strap_id;
	logic strap_taken, next_strap_taken;
	logic [7:0] scratch [NCS_SCR_DEPTH];
	logic [7:0] next_scratch [NCS_SCR_DEPTH];
	logic [7:0] next_reg_rdata;
	ncs_mem_req_t next_mem_req;
	ncs_bus_req_t next_map_req;
	ncs_event_t next_evt;
	logic [4:0] next_active_condition;
	logic next_load_busy;
	logic sw_save, sw_load, boot_load;
	logic [5:0] scr_idx;
	logic [7:0] move_byte;
	logic [NCS_STORE_AW-1:0] np_inc;

	assign scr_idx = 6'(reg_req.addr - NCS_REG_SCR_FIRST);
	assign np_inc = (np + 1'b1) & PTR_MASK; // (R1)
	assign move_byte = mode_load ? mem_rdata : map_rdata;

	// ***************************************************************
	// Next-state logic
	// ***************************************************************
	always_comb begin
		next_state = state;
		next_mode_load = mode_load;
		next_stage = stage;
		next_cur = cur;
		next_sp = sp;
		next_np = np;
		next_count = count;
		next_cks = cks;
		next_map_ptr = map_ptr;
		next_addr_hi = addr_hi;
		next_wr_en = wr_en;
		next_cond_reg = cond_reg;
		next_done = done;
		next_fault = fault;
		next_strap_id = strap_id;
		next_strap_taken = strap_taken;
		next_scratch = scratch;
		next_reg_rdata = reg_rdata;
		next_mem_req = '0;
		next_map_req = '0;
		next_evt = '0;
		sw_save = 1'b0;
		sw_load = 1'b0;
		boot_load = 1'b0;

		// Register port
		if (reg_req.wr) begin
			if (ncs_is_scratch(reg_req.addr)) begin
				next_scratch[scr_idx] = reg_req.wdata; // (R3)
			end
			next_wr_en = (reg_req.addr == NCS_REG_CTRL) ? reg_req.wdata[NCS_WE_BIT] : wr_en;
			next_cond_reg = (reg_req.addr == NCS_REG_COND) ? reg_req.wdata[3:0] : cond_reg;
			sw_save = (reg_req.addr == NCS_REG_SAVE) && reg_req.wdata[NCS_SAVE_BIT] && wr_en; // (R22)
			sw_load = (reg_req.addr == NCS_REG_LOAD) && reg_req.wdata[NCS_LOAD_BIT]; // (R23)
		end
		if (reg_req.rd) begin
			next_reg_rdata = 8'h00;
			if (ncs_is_scratch(reg_req.addr)) begin
				next_reg_rdata = scratch[scr_idx];
			end else if (reg_req.addr == NCS_REG_CTRL) begin
				next_reg_rdata[NCS_WE_BIT] = wr_en;
			end else if (reg_req.addr == NCS_REG_COND) begin
				next_reg_rdata[3:0] = cond_reg;
			end else if (reg_req.addr == NCS_REG_STATUS) begin
				next_reg_rdata[NCS_ST_SAVE_BUSY] = (state != NCS_ST_IDLE) && !mode_load;
				next_reg_rdata[NCS_ST_LOAD_BUSY] = load_busy; // (R25)
				next_reg_rdata[NCS_ST_DONE] = done;
				next_reg_rdata[NCS_ST_FAULT] = fault;
			end
		end

		// Straps are caught on the first cycle after reset release
		if (!strap_taken) begin
			next_strap_taken = 1'b1;
			next_strap_id = ncs_strap_id(config_select_pin_high, config_select_pin_low);
			boot_load = auto_load_en && (next_strap_id != 5'h00); // (R2)
		end

		unique case (state)
			NCS_ST_IDLE: begin
				if (boot_load || sw_load) begin
					next_mode_load = 1'b1; // (R5)
					next_state = NCS_ST_FETCH;
					next_stage = 2'd0;
					next_np = PTR_ZERO;
					next_done = 1'b0;
					next_fault = 1'b0;
				end else if (sw_save) begin
					next_mode_load = 1'b0;
					next_state = NCS_ST_FETCH;
					next_stage = 2'd0;
					next_sp = 6'd0; // (R24)
				end
			end
			NCS_ST_FETCH: begin
				next_mem_req.rd = mode_load;
				next_mem_req.addr = np;
				next_state = NCS_ST_WAIT;
			end
			NCS_ST_WAIT: begin
				// Running off the scratch pad acts as an end instruction
				if (mode_load) begin
					next_cur = mem_rdata;
				end else if (sp > SCR_LAST_IDX) begin
					next_cur = NCS_INS_END;
				end else begin
					next_cur = scratch[sp]; // (R24)
				end
				next_state = NCS_ST_DECODE;
			end
			NCS_ST_DECODE: begin
				if (stage != 2'd0 || cur != NCS_INS_PAUSE || mode_load) begin
					// Save stores every byte but a pause, end code too, so a restore halts there
					if (!mode_load) begin
						next_mem_req.wr = 1'b1; // (R27)
						next_mem_req.addr = np;
						next_mem_req.wdata = cur;
						next_sp = sp + 6'd1;
					end
					next_np = np_inc;
					next_state = NCS_ST_FETCH;
				end
				if (stage == 2'd1) begin
					next_addr_hi = cur; // (R16)
					next_stage = 2'd2;
				end else if (stage == 2'd2) begin
					next_map_ptr = {addr_hi, cur}; // (R16)
					next_stage = 2'd0;
					next_state = NCS_ST_MOVE_REQ; // (R15)
				end else if (cur <= NCS_INS_DATA_MAX) begin
					next_count = cur + 8'd1; // (R6)
					next_cks = NCS_CKS_RESET;
					next_stage = 2'd1; // (R15)
				end else if (cur == NCS_INS_END) begin
					next_np = PTR_ZERO; // (R12) (R13)
					next_sp = mode_load ? next_sp : 6'd0; // (R12)
					next_done = mode_load ? !fault : done; // (R20)
					next_state = NCS_ST_IDLE;
				end else if (cur == NCS_INS_PAUSE && !mode_load) begin
					next_state = NCS_ST_IDLE; // (R11) (R14) (R21)
				end else if (mode_load) begin
					// Pause falls through here on restore and is skipped
					next_evt.io_update = (cur == NCS_INS_IO_UPDATE); // (R7)
					next_evt.calibrate = (cur == NCS_INS_CAL); // (R8)
					next_evt.dist_sync = (cur == NCS_INS_SYNC); // (R9)
					next_evt.cond_valid = (cur >= NCS_INS_COND_FIRST && cur <= NCS_INS_COND_LAST); // (R10)
					next_evt.cond = next_evt.cond_valid ? 5'(cur - NCS_INS_COND_FIRST) : 5'h00;
				end
			end
			NCS_ST_MOVE_REQ: begin
				next_mem_req.rd = mode_load;
				next_mem_req.addr = np;
				next_map_req.rd = !mode_load;
				next_map_req.addr = map_ptr;
				next_state = NCS_ST_MOVE_WAIT;
			end
			NCS_ST_MOVE_WAIT: begin
				next_map_req.wr = mode_load;
				next_map_req.addr = map_ptr;
				next_map_req.wdata = move_byte;
				next_mem_req.wr = !mode_load;
				next_mem_req.addr = np;
				next_mem_req.wdata = move_byte;
				next_np = np_inc;
				next_map_ptr = map_ptr + 16'd1; // (R17)
				next_cks = cks + move_byte; // (R26)
				next_count = count - 8'd1;
				next_state = (count == 8'd1) ? NCS_ST_CK_REQ : NCS_ST_MOVE_REQ;
			end
			NCS_ST_CK_REQ: begin
				if (mode_load) begin
					next_mem_req.rd = 1'b1;
					next_mem_req.addr = np;
					next_state = NCS_ST_CK_WAIT;
				end else begin
					next_mem_req.wr = 1'b1; // (R18)
					next_mem_req.addr = np;
					next_mem_req.wdata = cks;
					next_np = np_inc;
					next_state = NCS_ST_FETCH;
				end
			end
			NCS_ST_CK_WAIT: begin
				next_fault = fault || (mem_rdata != cks); // (R19)
				next_np = np_inc;
				next_state = NCS_ST_FETCH;
			end
			default: begin
				next_state = NCS_ST_IDLE;
			end
		endcase

		// Nonzero software condition overrides the strap condition
		next_active_condition = (next_cond_reg != 4'h0) ? {1'b0, next_cond_reg} : next_strap_id;
		next_load_busy = (next_state != NCS_ST_IDLE) && next_mode_load; // (R25)
	end

	// ***************************************************************
	// Registers
	// ***************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= NCS_ST_IDLE;
			mode_load <= 1'b0;
			stage <= 2'd0;
			cur <= 8'h00;
			sp <= 6'd0;
			np <= PTR_ZERO;
			count <= 8'h00;
			cks <= NCS_CKS_RESET;
			map_ptr <= 16'h0000;
			addr_hi <= 8'h00;
			wr_en <= NCS_WE_RESET;
			cond_reg <= NCS_COND_RESET;
			done <= 1'b0;
			fault <= 1'b0;
			strap_id <= 5'h00;
			strap_taken <= 1'b0;
			for (int i = 0; i < NCS_SCR_DEPTH; i++) begin
				scratch[i] <= ncs_scr_default(i); // (R4)
			end
			reg_rdata <= 8'h00;
			mem_req <= '0;
			map_req <= '0;
			evt <= '0;
			active_condition <= 5'h00;
			load_busy <= 1'b0;
		end else begin
			state <= next_state;
			mode_load <= next_mode_load;
			stage <= next_stage;
			cur <= next_cur;
			sp <= next_sp;
			np <= next_np;
			count <= next_count;
			cks <= next_cks;
			map_ptr <= next_map_ptr;
			addr_hi <= next_addr_hi;
			wr_en <= next_wr_en;
			cond_reg <= next_cond_reg;
			done <= next_done;
			fault <= next_fault;
			strap_id <= next_strap_id;
			strap_taken <= next_strap_taken;
			scratch <= next_scratch;
			reg_rdata <= next_reg_rdata;
			mem_req <= next_mem_req;
			map_req <= next_map_req;
			evt <= next_evt;
			active_condition <= next_active_condition;
			load_busy <= next_load_busy;
		end
	end

endmodule

`default_nettype wire

/* verification/ncs_store_model.sv */
// Behavioural store and register map on the sequencer's far side.
// Assumes one-cycle read latency on both ports; idle read data toggles.
`timescale 1ns/1ps
`default_nettype none
module ncs_store_model (
	input wire logic clk,
	input wire ncs_pkg::ncs_mem_req_t mem_req,
	output logic [7:0] mem_rdata,
	input wire ncs_pkg::ncs_bus_req_t map_req,
	output logic [7:0] map_rdata
);
	import ncs_pkg::*;
	logic [7:0] store [0:NCS_STORE_BYTES-1];
	logic [7:0] map_mem [0:65535];
	logic [7:0] idle_q = 8'h5A;
	initial begin
		foreach (store[i]) store[i] = 8'hFF;
		foreach (map_mem[i]) map_mem[i] = 8'h00;
	end
	// Read data stands only while the strobe is high; otherwise it toggles
	assign mem_rdata = mem_req.rd ? store[mem_req.addr] : idle_q;
	assign map_rdata = map_req.rd ? map_mem[map_req.addr] : ~idle_q;
	always @(posedge clk) begin
		if (mem_req.wr) store[mem_req.addr] <= mem_req.wdata;
		if (map_req.wr) map_mem[map_req.addr] <= map_req.wdata;
		idle_q <= ~idle_q;
	end
endmodule
`default_nettype wire

/* verification/ncs_seq_props.sv */
// Port-level checker for the configuration sequencer.
// Assumes a bind onto ncs_sequencer, single clock domain.
`timescale 1ns/1ps
`default_nettype none
module ncs_seq_props #(
	parameter int STORE_BYTES = ncs_pkg::NCS_STORE_BYTES
) (
	input wire logic clk,
	input wire logic srst,
	input wire ncs_pkg::ncs_bus_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire ncs_pkg::ncs_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	input wire ncs_pkg::ncs_bus_req_t map_req,
	input wire logic [7:0] map_rdata,
	input wire logic auto_load_en,
	input wire logic [1:0] config_select_pin_low,
	input wire logic [1:0] config_select_pin_high,
	input wire ncs_pkg::ncs_event_t evt,
	input wire logic [4:0] active_condition,
	input wire logic load_busy
);
	import ncs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ***************************************************************
	// Assertions
	// ***************************************************************
	sequence s_store_wr;
		##[1:2] mem_req.wr;
	endsequence
	sequence s_boot_busy;
		##[1:3] load_busy;
	endsequence
	io_pulse_a: assert property (evt.io_update |=> !evt.io_update)
		else $error("io update longer than one cycle");
	cal_load_a: assert property (evt.calibrate |-> load_busy)
		else $error("calibrate outside download");
	sync_load_a: assert property (evt.dist_sync |-> load_busy)
		else $error("sync outside download");
	cond_load_a: assert property (evt.cond_valid |-> load_busy)
		else $error("condition outside download");
	save_move_a: assert property (map_req.rd |-> s_store_wr)
		else $error("map byte not stored");
	map_wr_a: assert property (map_req.wr |-> load_busy && !mem_req.wr)
		else $error("map write outside download");
	map_rd_a: assert property (map_req.rd |-> !load_busy)
		else $error("map read during download");
	store_wr_a: assert property (mem_req.wr |-> !load_busy && !mem_req.rd)
		else $error("store write during download");
	rdata_hold_a: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
		else $error("read data changed without read");
	boot_load_a: assert property ($fell(srst) && auto_load_en
		&& !(config_select_pin_low == NCS_PIN_OPEN && config_select_pin_high == NCS_PIN_OPEN)
		|-> s_boot_busy)
		else $error("boot download not started");
	store_rng_a: assert property (mem_req.wr |-> int'(mem_req.addr) < STORE_BYTES)
		else $error("store address out of range");
endmodule
bind ncs_sequencer ncs_seq_props #(.STORE_BYTES(STORE_BYTES)) i_ncs_seq_props (
	.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.mem_req(mem_req), .mem_rdata(mem_rdata), .map_req(map_req), .map_rdata(map_rdata),
	.auto_load_en(auto_load_en), .config_select_pin_low(config_select_pin_low),
	.config_select_pin_high(config_select_pin_high), .evt(evt),
	.active_condition(active_condition), .load_busy(load_busy)
);
`default_nettype wire

/* verification/nvm_config_sequencer_test.sv */
// Self-checking bench: boot load, save, appended save, restore, fault.
// Assumes the behavioural store model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module nvm_config_sequencer_test;
	import ncs_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	ncs_bus_req_t reg_req = '0;
	logic [7:0] reg_rdata, mem_rdata, map_rdata, d;
	ncs_mem_req_t mem_req;
	ncs_bus_req_t map_req;
	ncs_event_t evt;
	logic [4:0] active_condition;
	logic load_busy;
	logic [4:0] last_cond = 5'h00;
	logic auto_ld = 1'b1;
	logic [1:0] sel_low = NCS_PIN_LOW;
	logic [1:0] sel_high = NCS_PIN_LOW;
	logic busy_seen = 1'b0;
	int n_mismatch = 0;
	int checks = 0;
	int n_io = 0, n_cal = 0, n_sync = 0;
	logic [7:0] dflt [5] = '{8'h7F, 8'h00, 8'h00, 8'h80, 8'hFF};
	logic [7:0] exp1 [16] = '{8'h01, 8'h00, 8'h20, 8'h11, 8'h22, 8'h33, 8'h80, 8'hA0,
		8'hA1, 8'hB3, 8'h00, 8'h00, 8'h30, 8'h5A, 8'h5A, 8'hFF};
	always #2.5 clk = ~clk;
	ncs_sequencer i_ncs_sequencer (.clk(clk), .srst(srst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata), .map_req(map_req),
		.map_rdata(map_rdata), .auto_load_en(auto_ld), .config_select_pin_low(sel_low),
		.config_select_pin_high(sel_high), .evt(evt),
		.active_condition(active_condition), .load_busy(load_busy));
	ncs_store_model i_ncs_store_model (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.map_req(map_req), .map_rdata(map_rdata));
	always @(posedge clk) begin
		if (evt.io_update === 1'b1) n_io++;
		if (evt.calibrate === 1'b1) n_cal++;
		if (evt.dist_sync === 1'b1) n_sync++;
		if (evt.cond_valid === 1'b1) last_cond = evt.cond;
		if (load_busy === 1'b1) busy_seen = 1'b1;
	end
	// ***************************************************************
	// Access tasks
	// ***************************************************************
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_req.addr = a;
		reg_req.wdata = v;
		reg_req.wr = 1'b1;
		@(negedge clk);
		reg_req.wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [15:0] a);
		@(negedge clk);
		reg_req.addr = a;
		reg_req.rd = 1'b1;
		@(negedge clk);
		reg_req.rd = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Bounded poll; leaves the last status in d
	task automatic wait_idle;
		for (int i = 0; i < 3000; i++) begin
			reg_rd(NCS_REG_STATUS);
			if (d[1:0] === 2'b00) break;
		end
		chk("busy", 8'h00, {6'h00, d[1:0]});
	endtask
	task automatic prog(input logic [7:0] s [$]);
		foreach (s[i]) reg_wr(16'(NCS_REG_SCR_FIRST + i), s[i]);
	endtask
	// Reset with new strap levels, then let any boot download finish
	task automatic restart(input logic en, input logic [1:0] hi, input logic [1:0] lo);
		@(negedge clk);
		auto_ld = en;
		sel_high = hi;
		sel_low = lo;
		busy_seen = 1'b0;
		srst = 1'b1;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		wait_idle();
	endtask
	task automatic give_verdict;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ***************************************************************
	// Tests
	// ***************************************************************
	initial begin
		restart(1'b1, NCS_PIN_LOW, NCS_PIN_LOW);
		chk("boot_busy", 8'h01, {7'h00, busy_seen});
		chk("condition", 8'h01, {3'h0, active_condition});
		for (int i = 0; i < 5; i++) begin
			reg_rd(16'(NCS_REG_SCR_FIRST + i));
			chk("scratch", dflt[i], d);
		end
		reg_rd(NCS_REG_CTRL);
		chk("ctrl", 8'h00, d);
		reg_wr(NCS_REG_COND, 8'h05);
		reg_rd(NCS_REG_COND);
		chk("cond_reg", 8'h05, d);
		chk("act_cond", 8'h05, {3'h0, active_condition});
		reg_wr(NCS_REG_COND, 8'h00);
		reg_rd(16'h0100);
		chk("unmapped", 8'h00, d);
		i_ncs_store_model.map_mem[16'h0020] = 8'h11;
		i_ncs_store_model.map_mem[16'h0021] = 8'h22;
		i_ncs_store_model.map_mem[16'h0030] = 8'h5A;
		prog('{8'h01, 8'h00, 8'h20, 8'h80, 8'hA0, 8'hA1, 8'hB3, 8'hFE});
		reg_wr(NCS_REG_SAVE, 8'h01);
		repeat (40) @(negedge clk);
		chk("no_save", 8'hFF, i_ncs_store_model.store[0]);
		reg_wr(NCS_REG_CTRL, 8'h01);
		reg_wr(NCS_REG_SAVE, 8'h01);
		wait_idle();
		chk("pause", 8'hFF, i_ncs_store_model.store[10]);
		i_ncs_store_model.store[15] = 8'h00;
		prog('{8'h00, 8'h00, 8'h30, 8'hFF});
		reg_wr(NCS_REG_SAVE, 8'h01);
		wait_idle();
		foreach (exp1[i]) chk("store", exp1[i], i_ncs_store_model.store[i]);
		i_ncs_store_model.map_mem[16'h0020] = 8'h00;
		i_ncs_store_model.map_mem[16'h0021] = 8'h00;
		i_ncs_store_model.map_mem[16'h0030] = 8'h00;
		reg_wr(NCS_REG_LOAD, 8'h02);
		wait_idle();
		chk("status", 8'h04, d & 8'h0C);
		chk("map20", 8'h11, i_ncs_store_model.map_mem[16'h0020]);
		chk("map21", 8'h22, i_ncs_store_model.map_mem[16'h0021]);
		chk("map30", 8'h5A, i_ncs_store_model.map_mem[16'h0030]);
		chk("io", 8'h01, 8'(n_io));
		chk("cal", 8'h01, 8'(n_cal));
		chk("sync", 8'h01, 8'(n_sync));
		chk("cond", 8'h03, {3'h0, last_cond});
		i_ncs_store_model.store[5] = 8'h34;
		reg_wr(NCS_REG_LOAD, 8'h02);
		wait_idle();
		chk("fault", 8'h08, d & 8'h0C);
		restart(1'b1, NCS_PIN_OPEN, NCS_PIN_OPEN);
		chk("no_boot", 8'h00, {7'h00, busy_seen});
		chk("null_id", 8'h00, {3'h0, active_condition});
		restart(1'b0, NCS_PIN_LOW, NCS_PIN_LOW);
		chk("pin_off", 8'h00, {7'h00, busy_seen});
		chk("pin_id", 8'h01, {3'h0, active_condition});
		restart(1'b1, NCS_PIN_HIGH, NCS_PIN_OPEN);
		chk("boot_busy2", 8'h01, {7'h00, busy_seen});
		chk("boot_id", 8'h07, {3'h0, active_condition});
		chk("boot_fault", 8'h08, d & 8'h0C);
		give_verdict();
	end
	initial begin
		#200000;
		n_mismatch++;
		$display("Error watchdog expected done seen hang");
		give_verdict();
	end
endmodule
`default_nettype wire
